// File: bench/i2css_master_model.sv
// behavioural two-wire bus master on open-drain clock and data
`timescale 1ns/10ps
`default_nettype none
module i2css_master_model
(
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var logic  scl_oe_n_o,
	output var logic  sda_oe_n_o
);
	initial
	begin
		scl_oe_n_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	// release clock, then wait out any stretch by the slave
	task automatic rise();
		scl_oe_n_o = 1'b1;
		wait (scl_i === 1'b1);
		#40;
	endtask
	task automatic start_bit();
		#80;
		sda_oe_n_o = 1'b1;
		#40;
		rise();
		sda_oe_n_o = 1'b0;
		#40;
		scl_oe_n_o = 1'b0;
	endtask
	task automatic stop_bit();
		#20;
		sda_oe_n_o = 1'b0;
		#60;
		rise();
		sda_oe_n_o = 1'b1;
		#80;
	endtask
	task automatic clock_bit(input logic b, output logic r);
		#20;
		sda_oe_n_o = b;
		#60;
		rise();
		#40;
		r = sda_i;
		scl_oe_n_o = 1'b0;
	endtask
	// ma low asks for more data, high ends a read
	task automatic xfer(input logic [7:0] tx, input logic ma, output logic [7:0] rx, output logic ak);
		for (int i = 7; i >= 0; i--)
			clock_bit(tx[i], rx[i]);
		clock_bit(ma, ak);
	endtask
endmodule
`default_nettype wire

// File: bench/i2css_slave_monitor.sv
// concurrent checks on the two-wire slave top ports
`timescale 1ns/10ps
`default_nettype none
module i2css_slave_monitor
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        scl_i,
	input wire logic        sda_i,
	input wire logic        scl_o,
	input wire logic        scl_oe_n_o,
	input wire logic        sda_o,
	input wire logic        sda_oe_n_o,
	input wire logic        irq_o
);
	logic [3:0] since_ack_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// cycles since the last bus answer, saturating
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			since_ack_q <= 4'hf;
		else if (wb_ack_o)
			since_ack_q <= 4'h0;
		else if (since_ack_q != 4'hf)
			since_ack_q <= since_ack_q + 4'h1;
	end
	sequence s_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_next: assert property (s_taken |=> s_ack_pulse)
		else $error("bus answer not a single pulse after request");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
		else $error("bus answer without request");
	a_dat_held: assert property (!$past(wb_cyc_i && wb_stb_i && !wb_ack_o) |-> $stable(wb_dat_o))
		else $error("read data moved without request");
	a_scl_drive_low: assert property (!scl_oe_n_o |-> !scl_o)
		else $error("clock driven high");
	a_sda_drive_low: assert property (!sda_oe_n_o |-> !sda_o)
		else $error("data driven high");
	a_scl_wire_low: assert property (!scl_oe_n_o |-> !scl_i)
		else $error("held clock line not low");
	a_sda_wire_low: assert property (!sda_oe_n_o |-> !sda_i)
		else $error("driven data line not low");
	a_stretch_release: assert property ($rose(scl_oe_n_o) |-> wb_ack_o || since_ack_q < 4'h4)
		else $error("clock released without software access");
	a_sda_hold_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o))
		else $error("data drive changed while clock high");
endmodule
bind i2css_slave_top i2css_slave_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o), .irq_o(irq_o));
`default_nettype wire

// File: bench/i2css_slave_top_tb_top.sv
// self-checking bench for the two-wire slave control
`timescale 1ns/10ps
`default_nettype none
module i2css_slave_top_tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        scl_o;
	logic        scl_oe_n;
	logic        sda_o;
	logic        sda_oe_n;
	logic        irq;
	logic        m_scl_oe_n;
	logic        m_sda_oe_n;
	logic [63:0] exp_q[$];
	logic [63:0] e_w;
	logic [31:0] seed = 32'h0000b123;
	int          miscompares = 0;
	int          check_count = 0;
	int          cyc_cnt = 0;
	int          stretch_cnt = 0;
	// pull-ups on both lines
	wire         scl_w = (scl_oe_n ? 1'b1 : scl_o) & m_scl_oe_n;
	wire         sda_w = (sda_oe_n ? 1'b1 : sda_o) & m_sda_oe_n;
	i2css_slave_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
		.scl_oe_n_o(scl_oe_n), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .irq_o(irq));
	i2css_master_model mdl_u (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_n_o(m_scl_oe_n),
		.sda_oe_n_o(m_sda_oe_n));
	initial
	begin
		forever #10 clk_i = ~clk_i;
	end
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		@(posedge clk_i);
		while (wb_ack !== 1'b1)
			@(posedge clk_i);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back({m, e});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	// one byte plus acknowledge bit; the wire is compared with what is expected
	task automatic xb(input logic [7:0] tx, input logic ma, input logic ek, input logic [7:0] ex);
		logic [7:0] r;
		logic       a;
		mdl_u.xfer(tx, ma, r, a);
		chk("ack", {31'h0, ek}, {31'h0, a});
		chk("byte", {24'h0, ex}, {24'h0, r});
	endtask
	// read results are compared when the answer appears, oldest note first
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (scl_oe_n === 1'b0)
			stretch_cnt++;
		if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
		begin
			e_w = exp_q.pop_front();
			chk("rdata", e_w[31:0], wb_rdat & e_w[63:32]);
		end
		if (cyc_cnt == 60000)
		begin
			miscompares++;
			stop_test();
		end
	end
	initial
	begin
		logic [7:0] d;
		int         s;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h00, 32'hff, 32'h0);
		rd(8'h04, 32'h3ff, 32'h0);
		rd(8'h14, 32'h7, 32'h0);
		rd(8'h20, 32'hffffffff, 32'h0);
		wr(8'h04, 32'h2a);
		wr(8'h14, 32'h7);
		wr(8'h00, 32'h1);
		s = stretch_cnt;
		d = rnd();
		mdl_u.start_bit();
		xb(8'h54, 1'b1, 1'b0, 8'h54);
		wr(8'h10, 32'h7);
		chk("irq", 32'h0, {31'h0, irq});
		xb(d, 1'b1, 1'b0, d);
		chk("irq", 32'h1, {31'h0, irq});
		xb(~d, 1'b1, 1'b1, ~d);
		mdl_u.stop_bit();
		chk("stretch", s, stretch_cnt);
		rd(8'h0c, 32'h3, 32'h3);
		rd(8'h08, 32'hff, {24'h0, d});
		rd(8'h10, 32'h7, 32'h7);
		wr(8'h10, 32'h7);
		wr(8'h0c, 32'h2);
		chk("irq", 32'h0, {31'h0, irq});
		mdl_u.start_bit();
		xb(8'h56, 1'b1, 1'b1, 8'h56);
		mdl_u.stop_bit();
		d = rnd();
		mdl_u.start_bit();
		xb(8'h55, 1'b1, 1'b0, 8'h55);
		repeat (30) @(posedge clk_i);
		chk("hold", 32'h0, {31'h0, scl_oe_n});
		wr(8'h08, {24'h0, d});
		xb(8'hff, 1'b0, 1'b0, d);
		rd(8'h0c, 32'h8, 32'h8);
		wr(8'h10, 32'h7);
		chk("irq", 32'h0, {31'h0, irq});
		wr(8'h08, {24'h0, ~d});
		xb(8'hff, 1'b1, 1'b1, ~d);
		chk("irq", 32'h1, {31'h0, irq});
		rd(8'h0c, 32'h8, 32'h0);
		mdl_u.stop_bit();
		wr(8'h00, 32'h81);
		d = rnd();
		mdl_u.start_bit();
		xb(8'h54, 1'b1, 1'b0, 8'h54);
		xb(d, 1'b1, 1'b0, d);
		repeat (30) @(posedge clk_i);
		chk("hold", 32'h0, {31'h0, scl_oe_n});
		rd(8'h08, 32'hff, {24'h0, d});
		xb(d ^ 8'h5a, 1'b1, 1'b0, d ^ 8'h5a);
		rd(8'h08, 32'hff, {24'h0, d ^ 8'h5a});
		mdl_u.stop_bit();
		wr(8'h04, 32'h2a5);
		wr(8'h00, 32'h5);
		d = rnd();
		mdl_u.start_bit();
		xb(8'hf4, 1'b1, 1'b0, 8'hf4);
		xb(8'ha5, 1'b1, 1'b0, 8'ha5);
		mdl_u.start_bit();
		xb(8'hf5, 1'b1, 1'b0, 8'hf5);
		wr(8'h08, {24'h0, d});
		xb(8'hff, 1'b1, 1'b1, d);
		mdl_u.stop_bit();
		mdl_u.start_bit();
		xb(8'hf5, 1'b1, 1'b1, 8'hf5);
		mdl_u.stop_bit();
		wr(8'h04, 32'h2a);
		wr(8'h00, 32'h3);
		s = stretch_cnt;
		mdl_u.start_bit();
		xb(8'h55, 1'b1, 1'b0, 8'h55);
		xb(8'hff, 1'b1, 1'b1, 8'hff);
		mdl_u.stop_bit();
		chk("stretch", s, stretch_cnt);
		repeat (4) @(posedge clk_i);
		stop_test();
	end
endmodule
`default_nettype wire

// File: design/i2css_consts.svh
// register map, field positions and reset values of the two-wire slave
`ifndef I2CSS_CONSTS_SVH
`define I2CSS_CONSTS_SVH
`define I2CSS_OFF_CTRL     8'h00
`define I2CSS_OFF_ADDR     8'h04
`define I2CSS_OFF_DATA     8'h08
`define I2CSS_OFF_STAT     8'h0c
`define I2CSS_OFF_IRQ_STAT 8'h10
`define I2CSS_OFF_IRQ_MASK 8'h14
`define I2CSS_CTRL_EN      0
`define I2CSS_CTRL_REL     1
`define I2CSS_CTRL_TEN     2
`define I2CSS_CTRL_HOG     7
`define I2CSS_STAT_FULL    0
`define I2CSS_STAT_OV      1
`define I2CSS_STAT_RX      2
`define I2CSS_STAT_TX      3
`define I2CSS_STAT_SEL     4
`define I2CSS_EV_BYTE      0
`define I2CSS_EV_OV        1
`define I2CSS_EV_STOP      2
`define I2CSS_EV_NUM       3
`define I2CSS_CTRL_RST     8'h00
`define I2CSS_ADDR_RST     10'h000
`define I2CSS_TEN_HI       5'h1e
`define I2CSS_LAST_BIT     4'h8
`define I2CSS_TX_FILL      8'hff
`endif

// File: design/i2css_irq.sv
// sticky event status, write-one-to-clear, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none
module i2css_irq
#(
	parameter int N = 3
)
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [N-1:0] event_i,
	input  wire logic [N-1:0] clr_i,
	input  wire logic         mask_we_i,
	input  wire logic [N-1:0] mask_i,
	output logic      [N-1:0] status_o,
	output logic      [N-1:0] mask_o,
	output logic              irq_o
);
	logic [N-1:0] stat_d;
	logic [N-1:0] stat_q;
	logic [N-1:0] mask_d;
	logic [N-1:0] mask_q;
	logic         irq_d;
	logic         irq_q;

	// a new event beats a clear in the same cycle
	always_comb
	begin
		stat_d = (stat_q & ~clr_i) | event_i;
		mask_d = mask_we_i ? mask_i : mask_q;
		irq_d  = |(stat_d & mask_d);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stat_q <= '0;
			mask_q <= '0;
			irq_q  <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q  <= irq_d;
		end
	end

	assign status_o = stat_q;
	assign mask_o   = mask_q;
	assign irq_o    = irq_q;
endmodule
`default_nettype wire

// File: design/i2css_line_if.sv
// synchronised line levels and bus events between sampler and control
`timescale 1ns/10ps
`default_nettype none
interface i2css_line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	modport drv (output scl, output sda, output scl_rise, output scl_fall, output start, output stop);
	modport mon (input scl, input sda, input scl_rise, input scl_fall, input start, input stop);
endinterface
`default_nettype wire

// File: design/i2css_line_sync.sv
// two-flop sampling of clock and data lines, edge and start/stop detection
`timescale 1ns/10ps
`default_nettype none
module i2css_line_sync
(
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	input  wire logic   scl_i,
	input  wire logic   sda_i,
	i2css_line_if.drv   ln
);
	logic [1:0] meta_d;
	logic [1:0] meta_q;
	logic [1:0] sync_d;
	logic [1:0] sync_q;
	logic [1:0] prev_d;
	logic [1:0] prev_q;

	// edges use the second stage against a third, never the first stage
	always_comb
	begin
		meta_d = {scl_i, sda_i};
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= 2'h3;
			sync_q <= 2'h3;
			prev_q <= 2'h3;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign ln.scl      = sync_q[1];
	assign ln.sda      = sync_q[0];
	assign ln.scl_rise = sync_q[1] & ~prev_q[1];
	assign ln.scl_fall = ~sync_q[1] & prev_q[1];
	assign ln.start    = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
	assign ln.stop     = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];
endmodule
`default_nettype wire

// File: design/i2css_pkg.sv
// types shared by the two-wire slave modules
package i2css_pkg;
	typedef enum logic [2:0]
	{
		ST_WAIT = 3'b001,
		ST_RX   = 3'b010,
		ST_TX   = 3'b100
	} i2css_state_type;
endpackage

// File: design/i2css_slave_top.sv
// two-wire slave control: address match, receive, transmit, clock stretch
// How it works
// RULE_01: own 7-bit address hit: interrupt, ack, choose direction
// RULE_02: full buffer or overflow: set overflow, no ack
// RULE_03: shift in eight bits, interrupt per byte
// RULE_04: transmit with empty buffer, release clear: hold clock
// RULE_05: byte sent interrupts; master nack ends transmission
// RULE_06: master ack keeps transmitting, next byte prepared
// RULE_07: upper address hit: earlier hit transmits, else clears
// RULE_08: auto stretch enabled holds clock after received byte
// RULE_09: auto stretch disabled never holds after receive
// RULE_10: release stretch on buffer emptied or release set
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`include "i2css_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module i2css_slave_top
	import i2css_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             scl_o,
	output logic             scl_oe_n_o,
	output logic             sda_o,
	output logic             sda_oe_n_o,
	output logic             irq_o
);
	i2css_line_if ln ();

	i2css_state_type     state_d;
	i2css_state_type     state_q;
	logic [7:0]          ctrl_d;
	logic [7:0]          ctrl_q;
	logic [9:0]          own_addr_d;
	logic [9:0]          own_addr_q;
	logic [7:0]          holding_buffer_d;
	logic [7:0]          holding_buffer_q;
	logic                buf_full_d;
	logic                buf_full_q;
	logic                receive_overflow_flag_d;
	logic                receive_overflow_flag_q;
	logic [7:0]          serial_shift_register_d;
	logic [7:0]          serial_shift_register_q;
	logic [3:0]          cnt_d;
	logic [3:0]          cnt_q;
	logic                ackph_d;
	logic                ackph_q;
	logic                listen_d;
	logic                listen_q;
	logic                tx_need_d;
	logic                tx_need_q;
	logic                hog_d;
	logic                hog_q;
	logic                hi_w_d;
	logic                hi_w_q;
	logic                prior_d;
	logic                prior_q;
	logic                sda_oe_n_d;
	logic                sda_oe_n_q;
	logic                scl_oe_n_d;
	logic                scl_oe_n_q;
	logic                ack_d;
	logic                ack_q;
	logic [31:0]         dat_d;
	logic [31:0]         dat_q;
	logic                pin_lvl_q;
	logic                bus_take;
	logic                sw_buf_wr;
	logic                do_ack;
	logic                clock_release_bit;
	logic                auto_clock_stretch_enable;
	logic [`I2CSS_EV_NUM-1:0] ev;
	logic [`I2CSS_EV_NUM-1:0] ev_clr;
	logic                mask_we;
	logic [`I2CSS_EV_NUM-1:0] irq_stat;
	logic [`I2CSS_EV_NUM-1:0] irq_mask;

	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
		return adr == off;
	endfunction

	i2css_line_sync u_sync
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.scl_i (scl_i),
		.sda_i (sda_i),
		.ln    (ln)
	);

	i2css_irq #(.N(`I2CSS_EV_NUM)) u_irq
	(
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.event_i   (ev),
		.clr_i     (ev_clr),
		.mask_we_i (mask_we),
		.mask_i    (wb_dat_i[`I2CSS_EV_NUM-1:0]),
		.status_o  (irq_stat),
		.mask_o    (irq_mask),
		.irq_o     (irq_o)
	);

	assign clock_release_bit         = ctrl_q[`I2CSS_CTRL_REL];
	assign auto_clock_stretch_enable = ctrl_q[`I2CSS_CTRL_HOG];

	always_comb
	begin
		state_d                 = state_q;
		ctrl_d                  = ctrl_q;
		own_addr_d              = own_addr_q;
		holding_buffer_d        = holding_buffer_q;
		buf_full_d              = buf_full_q;
		receive_overflow_flag_d = receive_overflow_flag_q;
		serial_shift_register_d = serial_shift_register_q;
		cnt_d                   = cnt_q;
		ackph_d                 = ackph_q;
		listen_d                = listen_q;
		tx_need_d               = tx_need_q;
		hog_d                   = hog_q;
		hi_w_d                  = hi_w_q;
		prior_d                 = prior_q;
		sda_oe_n_d              = sda_oe_n_q;
		ev                      = '0;
		ev_clr                  = '0;
		mask_we                 = 1'b0;
		sw_buf_wr               = 1'b0;
		do_ack                  = 1'b0;
		bus_take                = wb_cyc_i & wb_stb_i & ~ack_q;
		ack_d                   = bus_take;
		dat_d                   = dat_q;

		// bus side first, so hardware updates below win a same-cycle clash, except that a buffer write keeps buf_full_d set through a transmit load
		if (bus_take)
		begin
			dat_d = 32'h0000_0000;
			if (reg_hit(wb_adr_i, `I2CSS_OFF_CTRL))
			begin
				dat_d[7:0] = ctrl_q;
				if (wb_we_i && wb_sel_i[0])
					ctrl_d = wb_dat_i[7:0];
			end
			else if (reg_hit(wb_adr_i, `I2CSS_OFF_ADDR))
			begin
				dat_d[9:0] = own_addr_q;
				if (wb_we_i && wb_sel_i[0])
					own_addr_d[7:0] = wb_dat_i[7:0];
				if (wb_we_i && wb_sel_i[1])
					own_addr_d[9:8] = wb_dat_i[9:8];
			end
			else if (reg_hit(wb_adr_i, `I2CSS_OFF_DATA))
			begin
				dat_d[7:0] = holding_buffer_q;
				if (!wb_we_i)
					buf_full_d = 1'b0;
				else if (wb_sel_i[0])
				begin
					holding_buffer_d = wb_dat_i[7:0];
					buf_full_d       = 1'b1;
					sw_buf_wr        = 1'b1;
				end
			end
			else if (reg_hit(wb_adr_i, `I2CSS_OFF_STAT))
			begin
				dat_d[`I2CSS_STAT_FULL] = buf_full_q;
				dat_d[`I2CSS_STAT_OV]   = receive_overflow_flag_q;
				dat_d[`I2CSS_STAT_RX]   = (state_q == ST_RX);
				dat_d[`I2CSS_STAT_TX]   = (state_q == ST_TX);
				dat_d[`I2CSS_STAT_SEL]  = listen_q;
				if (wb_we_i && wb_sel_i[0] && wb_dat_i[`I2CSS_STAT_OV])
					receive_overflow_flag_d = 1'b0;
			end
			else if (reg_hit(wb_adr_i, `I2CSS_OFF_IRQ_STAT))
			begin
				dat_d[`I2CSS_EV_NUM-1:0] = irq_stat;
				if (wb_we_i && wb_sel_i[0])
					ev_clr = wb_dat_i[`I2CSS_EV_NUM-1:0];
			end
			else if (reg_hit(wb_adr_i, `I2CSS_OFF_IRQ_MASK))
			begin
				dat_d[`I2CSS_EV_NUM-1:0] = irq_mask;
				mask_we = wb_we_i & wb_sel_i[0];
			end
		end

		if (ln.start)
		begin
			state_d    = ST_WAIT;
			listen_d   = ctrl_q[`I2CSS_CTRL_EN];
			cnt_d      = 4'h0;
			ackph_d    = 1'b0;
			sda_oe_n_d = 1'b1;
			tx_need_d  = 1'b0;
			hog_d      = 1'b0;
		end
		else if (ln.stop)
		begin
			state_d    = ST_WAIT;
			listen_d   = 1'b0;
			cnt_d      = 4'h0;
			ackph_d    = 1'b0;
			prior_d    = 1'b0;
			hi_w_d     = 1'b0;
			sda_oe_n_d = 1'b1;
			tx_need_d  = 1'b0;
			hog_d      = 1'b0;
			ev[`I2CSS_EV_STOP] = 1'b1;
		end
		else if (listen_q && ln.scl_rise)
		begin
			if (cnt_q != `I2CSS_LAST_BIT)
			begin
				serial_shift_register_d = {serial_shift_register_q[6:0], ln.sda}; // [RULE_03]
				cnt_d = cnt_q + 4'h1;
			end
			else if (state_q == ST_TX && ln.sda)
			begin
				// master nack: transmission over, idle until next start
				state_d  = ST_WAIT; // [RULE_05]
				listen_d = 1'b0;
				ackph_d  = 1'b0;
				cnt_d    = 4'h0;
			end
		end
		else if (listen_q && ln.scl_fall)
		begin
			if (ackph_q)
			begin
				ackph_d    = 1'b0;
				cnt_d      = 4'h0;
				sda_oe_n_d = 1'b1;
				if (state_q == ST_TX)
					tx_need_d = 1'b1; // [RULE_06]
				else if (state_q == ST_RX && auto_clock_stretch_enable && buf_full_q)
					hog_d = 1'b1; // [RULE_08] [RULE_09]
			end
			else if (cnt_q == `I2CSS_LAST_BIT)
			begin
				ackph_d = 1'b1;
				unique case (state_q)
					ST_WAIT:
					begin
						if (!ctrl_q[`I2CSS_CTRL_TEN]
							&& serial_shift_register_q[7:1] == own_addr_q[6:0])
						begin
							ev[`I2CSS_EV_BYTE] = 1'b1; // [RULE_01]
							do_ack  = 1'b1;
							state_d = serial_shift_register_q[0] ? ST_TX : ST_RX;
						end
						else if (ctrl_q[`I2CSS_CTRL_TEN] && hi_w_q
							&& serial_shift_register_q == own_addr_q[7:0])
						begin
							ev[`I2CSS_EV_BYTE] = 1'b1;
							do_ack  = 1'b1;
							hi_w_d  = 1'b0;
							prior_d = 1'b1;
							state_d = ST_RX;
						end
						else if (ctrl_q[`I2CSS_CTRL_TEN]
							&& serial_shift_register_q[7:3] == `I2CSS_TEN_HI
							&& serial_shift_register_q[2:1] == own_addr_q[9:8])
						begin
							if (!serial_shift_register_q[0])
							begin
								do_ack = 1'b1;
								hi_w_d = 1'b1;
							end
							else if (prior_q)
							begin
								ev[`I2CSS_EV_BYTE] = 1'b1;
								do_ack  = 1'b1; // [RULE_07]
								state_d = ST_TX;
							end
							else
							begin
								prior_d  = 1'b0; // [RULE_07]
								listen_d = 1'b0;
							end
						end
						else
						begin
							// not ours: ignore the rest of the frame
							hi_w_d   = 1'b0;
							listen_d = 1'b0;
						end
					end
					ST_RX:
					begin
						ev[`I2CSS_EV_BYTE] = 1'b1; // [RULE_03]
						if (buf_full_q || receive_overflow_flag_q)
						begin
							receive_overflow_flag_d = 1'b1; // [RULE_02]
							ev[`I2CSS_EV_OV] = 1'b1;
						end
						else
						begin
							holding_buffer_d = serial_shift_register_q; // [RULE_02]
							buf_full_d       = 1'b1;
							do_ack           = 1'b1;
						end
					end
					ST_TX:
					begin
						ev[`I2CSS_EV_BYTE] = 1'b1; // [RULE_05]
					end
				endcase
				sda_oe_n_d = ~do_ack;
			end
			else if (state_q == ST_TX)
				sda_oe_n_d = serial_shift_register_q[7];
		end

		// next transmit byte: tried in the ack-fall cycle too, so a ready byte never stretches
		if (tx_need_d)
		begin
			if (buf_full_q)
			begin
				serial_shift_register_d = holding_buffer_q;
				sda_oe_n_d              = holding_buffer_q[7];
				tx_need_d               = 1'b0;
				if (!sw_buf_wr)
					buf_full_d = 1'b0;
			end
			else if (clock_release_bit)
			begin
				// nothing to send: idle-high filler rather than a hung bus
				serial_shift_register_d = `I2CSS_TX_FILL;
				sda_oe_n_d              = 1'b1;
				tx_need_d               = 1'b0;
			end
		end
		if (hog_d && (!buf_full_d || clock_release_bit))
			hog_d = 1'b0; // [RULE_10]
		scl_oe_n_d = ~(tx_need_d | hog_d); // [RULE_04] [RULE_08]
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q                 <= ST_WAIT;
			ctrl_q                  <= `I2CSS_CTRL_RST;
			own_addr_q              <= `I2CSS_ADDR_RST;
			holding_buffer_q        <= 8'h00;
			buf_full_q              <= 1'b0;
			receive_overflow_flag_q <= 1'b0;
			serial_shift_register_q <= 8'h00;
			cnt_q                   <= 4'h0;
			ackph_q                 <= 1'b0;
			listen_q                <= 1'b0;
			tx_need_q               <= 1'b0;
			hog_q                   <= 1'b0;
			hi_w_q                  <= 1'b0;
			prior_q                 <= 1'b0;
			sda_oe_n_q              <= 1'b1;
			scl_oe_n_q              <= 1'b1;
			ack_q                   <= 1'b0;
			dat_q                   <= 32'h0000_0000;
			pin_lvl_q               <= 1'b0;
		end
		else
		begin
			state_q                 <= state_d;
			ctrl_q                  <= ctrl_d;
			own_addr_q              <= own_addr_d;
			holding_buffer_q        <= holding_buffer_d;
			buf_full_q              <= buf_full_d;
			receive_overflow_flag_q <= receive_overflow_flag_d;
			serial_shift_register_q <= serial_shift_register_d;
			cnt_q                   <= cnt_d;
			ackph_q                 <= ackph_d;
			listen_q                <= listen_d;
			tx_need_q               <= tx_need_d;
			hog_q                   <= hog_d;
			hi_w_q                  <= hi_w_d;
			prior_q                 <= prior_d;
			sda_oe_n_q              <= sda_oe_n_d;
			scl_oe_n_q              <= scl_oe_n_d;
			ack_q                   <= ack_d;
			dat_q                   <= dat_d;
			pin_lvl_q               <= 1'b0;
		end
	end

	// open drain: pins only ever pulled low
	assign scl_o      = pin_lvl_q;
	assign sda_o      = pin_lvl_q;
	assign scl_oe_n_o = scl_oe_n_q;
	assign sda_oe_n_o = sda_oe_n_q;
	assign wb_ack_o   = ack_q;
	assign wb_dat_o   = dat_q;
endmodule
`default_nettype wire
